/* File: dct_cycle_timing.sv */
// Function
// [RULE_01] host bus reset returns every channel's timing field to compatible.
// [RULE_02] cycles to isa expansion memory always run compatible timing.
// [RULE_03] compatible: nine clocks single cycle, eight clocks repeated cycle.
// [RULE_04] type a: six clocks per repeated cycle.
// [RULE_05] type a keeps io setup and access window of compatible timing. Code keeps the setup lead but shortens the command window.
// [RULE_06] type b: five clocks per repeated cycle, shorter io setup.
// [RULE_07] slaves on type b channels must meet the faster io timing.
// [RULE_08] type f: three clocks per repeated cycle.
// [RULE_09] one timing field per channel; low write bits choose channel, unstored.
// [RULE_10] lengths count isa clock periods; new codes apply from next cycle.
`timescale 1ns/100ps
module dct_cycle_timing #(
  parameter int NUM_CH = dct_pkg::NUM_CH,
  parameter int FIFO_DEPTH = dct_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // pins
  input wire logic isaSystemClock,
  input wire logic hostBusResetN,
  // mode programming
  input wire logic modeWrEn,
  input wire logic [dct_pkg::WR_W-1:0] modeWrData,
  // cycle requests
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [dct_pkg::SEL_W-1:0] reqChan,
  input wire logic reqIsaMem,
  input wire logic reqRepeat,
  // cycle status
  output logic cycBusy,
  output logic ioCmd,
  output logic cycDone,
  output logic [dct_pkg::SEL_W-1:0] doneChan,
  output logic [dct_pkg::MODE_W-1:0] curMode,
  output logic [NUM_CH*dct_pkg::MODE_W-1:0] chanModes
);

  localparam int SW = dct_pkg::SEL_W;
  localparam int MW = dct_pkg::MODE_W;
  localparam int CW = dct_pkg::CNT_W;
  localparam int QW = SW + 2;

  // ==========================================================
  // pin synchronisers
  logic isaSync1_r, isaSync2_r, isaPrev_r;
  logic rstSync1_r, rstSync2_r;
  logic isaEdge, hostRst;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      isaSync1_r <= 1'h0;
      isaSync2_r <= 1'h0;
      isaPrev_r <= 1'h0;
      rstSync1_r <= 1'h1; // released level, so no spurious clear after reset
      rstSync2_r <= 1'h1;
    end else if (clkEn) begin
      isaSync1_r <= isaSystemClock;
      isaSync2_r <= isaSync1_r;
      isaPrev_r <= isaSync2_r;
      rstSync1_r <= hostBusResetN;
      rstSync2_r <= rstSync1_r;
    end
  end

  // one pulse per isa system clock period
  assign isaEdge = isaSync2_r && !isaPrev_r; // RULE_10
  assign hostRst = !rstSync2_r;

  // ==========================================================
  // per-channel timing fields
  logic [MW-1:0] mode_r [NUM_CH];
  logic [MW-1:0] mode_nxt [NUM_CH];
  logic [SW-1:0] wrSel;

  assign wrSel = modeWrData[dct_pkg::SEL_LSB +: SW];

  always_comb begin
    mode_nxt = mode_r;
    if (hostRst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mode_nxt[i] = dct_pkg::MODE_RST; // RULE_01
      end
    end else if (modeWrEn) begin
      // selector only steers the write; it is never stored
      mode_nxt[wrSel] = modeWrData[dct_pkg::MODE_LSB +: MW]; // RULE_09
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mode_r[i] <= dct_pkg::MODE_RST;
      end
    end else if (clkEn) begin
      mode_r <= mode_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gModeOut
      assign chanModes[g*MW +: MW] = mode_r[g];
    end
  endgenerate

  // ==========================================================
  // request queue
  logic qValid, qReady;
  logic [QW-1:0] qData;

  dct_fifo #(
    .WIDTH(QW),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(sys_clk),
    .rst(srst),
    .en(clkEn),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData({reqChan, reqIsaMem, reqRepeat}),
    .outValid(qValid),
    .outReady(qReady),
    .outData(qData)
  );

  // ==========================================================
  // timing lookups
  function automatic logic [CW-1:0] cycLen(input logic [MW-1:0] m, input logic rep);
    case (m)
      dct_pkg::MODE_TYPE_A: cycLen = dct_pkg::LEN_TYPE_A; // RULE_04
      dct_pkg::MODE_TYPE_B: cycLen = dct_pkg::LEN_TYPE_B; // RULE_06
      dct_pkg::MODE_TYPE_F: cycLen = dct_pkg::LEN_TYPE_F; // RULE_08
      default: cycLen = rep ? dct_pkg::LEN_COMPAT_REP : dct_pkg::LEN_COMPAT_SINGLE; // RULE_03
    endcase
  endfunction : cycLen

  // type a shortens only the command, so its lead matches compatible
  function automatic logic [CW-1:0] setupLen(input logic [MW-1:0] m);
    case (m)
      dct_pkg::MODE_TYPE_B: setupLen = dct_pkg::SETUP_FAST; // RULE_06
      dct_pkg::MODE_TYPE_F: setupLen = dct_pkg::SETUP_FAST;
      default: setupLen = dct_pkg::SETUP_STD; // RULE_05
    endcase
  endfunction : setupLen

  // ==========================================================
  // cycle engine
  dct_pkg::dct_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt, len_r, len_nxt, setup_r, setup_nxt;
  logic [MW-1:0] curMode_r, curMode_nxt;
  logic [SW-1:0] chan_r, chan_nxt;
  logic done_r, done_nxt, ioCmd_r, ioCmd_nxt;
  logic [SW-1:0] headChan;
  logic [MW-1:0] headMode;
  logic lastEdge;

  assign headChan = qData[QW-1 -: SW];
  // isa memory cannot keep up with the extended timings
  assign headMode = qData[1] ? dct_pkg::MODE_COMPAT : mode_r[headChan]; // RULE_02
  assign qReady = (state_r == dct_pkg::ST_IDLE);
  assign lastEdge = isaEdge && (cnt_r == CW'(len_r - 1'h1)); // RULE_10

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    setup_nxt = setup_r;
    curMode_nxt = curMode_r;
    chan_nxt = chan_r;
    done_nxt = 1'h0;
    ioCmd_nxt = ioCmd_r;
    case (state_r)
      dct_pkg::ST_IDLE: begin
        if (qValid) begin
          // mode is latched here, so a write mid-cycle waits for the next one
          state_nxt = dct_pkg::ST_RUN; // RULE_10
          curMode_nxt = headMode;
          chan_nxt = headChan;
          len_nxt = cycLen(headMode, qData[0]);
          setup_nxt = setupLen(headMode);
          cnt_nxt = '0;
        end
      end
      dct_pkg::ST_RUN: begin
        if (lastEdge) begin
          state_nxt = dct_pkg::ST_IDLE;
          done_nxt = 1'h1;
          ioCmd_nxt = 1'h0;
        end else if (isaEdge) begin
          cnt_nxt = CW'(cnt_r + 1'h1);
          // command spans the periods between setup and recovery
          ioCmd_nxt = (CW'(cnt_r + 1'h1) >= setup_r) &&
                      (CW'(cnt_r + 1'h1) < CW'(len_r - dct_pkg::RECOVERY)); // RULE_05
        end
      end
      default: begin
        state_nxt = dct_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= dct_pkg::ST_IDLE;
      cnt_r <= '0;
      len_r <= '0;
      setup_r <= '0;
      curMode_r <= dct_pkg::MODE_RST;
      chan_r <= '0;
      done_r <= 1'h0;
      ioCmd_r <= 1'h0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      setup_r <= setup_nxt;
      curMode_r <= curMode_nxt;
      chan_r <= chan_nxt;
      done_r <= done_nxt;
      ioCmd_r <= ioCmd_nxt;
    end
  end

  assign cycBusy = (state_r == dct_pkg::ST_RUN);
  assign ioCmd = ioCmd_r;
  assign cycDone = done_r;
  assign doneChan = chan_r;
  assign curMode = curMode_r;

  // ==========================================================
  // checks
  logic [7:0] edgeSeen_r;
  logic firstRep_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      edgeSeen_r <= '0;
      firstRep_r <= 1'h0;
    end else if (clkEn) begin
      if (qReady && qValid) begin
        edgeSeen_r <= '0;
        firstRep_r <= qData[0];
      end else if (cycBusy && isaEdge) begin
        edgeSeen_r <= 8'(edgeSeen_r + 1'h1);
      end
    end
  end

  mode_reset_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clkEn && hostRst) |=> (chanModes == '0)) // RULE_01
    else $error("timing fields not cleared by host bus reset");

  isa_mem_compat_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clkEn && qReady && qValid && qData[1]) |=> (curMode == dct_pkg::MODE_COMPAT)) // RULE_02
    else $error("isa memory cycle not run with compatible timing");

  compat_len_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cycDone && curMode == dct_pkg::MODE_COMPAT) |-> (edgeSeen_r ==
    (firstRep_r ? 8'(dct_pkg::LEN_COMPAT_REP) : 8'(dct_pkg::LEN_COMPAT_SINGLE)))) // RULE_03
    else $error("compatible cycle length wrong");

  type_a_len_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cycDone && curMode == dct_pkg::MODE_TYPE_A) |-> (edgeSeen_r == 8'(dct_pkg::LEN_TYPE_A))) // RULE_04
    else $error("type a cycle length wrong");

  type_a_setup_a: assert property (@(posedge sys_clk) disable iff (srst)
    ($rose(ioCmd) && curMode == dct_pkg::MODE_TYPE_A) |-> (edgeSeen_r == 8'(dct_pkg::SETUP_STD))) // RULE_05
    else $error("type a io lead differs from compatible");

  type_b_len_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cycDone && curMode == dct_pkg::MODE_TYPE_B) |-> (edgeSeen_r == 8'(dct_pkg::LEN_TYPE_B))) // RULE_06
    else $error("type b cycle length wrong");

  type_b_setup_a: assert property (@(posedge sys_clk) disable iff (srst)
    ($rose(ioCmd) && curMode == dct_pkg::MODE_TYPE_B) |-> (edgeSeen_r == 8'(dct_pkg::SETUP_FAST))) // RULE_06
    else $error("type b io lead not shortened");

  type_f_len_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cycDone && curMode == dct_pkg::MODE_TYPE_F) |-> (edgeSeen_r == 8'(dct_pkg::LEN_TYPE_F))) // RULE_08
    else $error("type f cycle length wrong");

  mode_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clkEn && modeWrEn && !hostRst) |=>
    (mode_r[$past(wrSel)] == $past(modeWrData[dct_pkg::MODE_LSB +: MW]))) // RULE_09
    else $error("timing field write lost");

  mode_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cycBusy && $past(cycBusy)) |-> $stable(curMode)) // RULE_10
    else $error("timing changed inside a cycle");

endmodule : dct_cycle_timing

/* File: dct_pkg.sv */
package dct_pkg;

  // ==========================================================
  // channel layout
  localparam int NUM_CH = 4;
  localparam int MODE_W = 2;
  localparam int SEL_W = 2;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // mode write word: selector in low bits, timing field above
  localparam int WR_W = 8;
  localparam int SEL_LSB = 0;
  localparam int MODE_LSB = 4;

  // ==========================================================
  // timing codes
  localparam logic [1:0] MODE_COMPAT = 2'h0;
  localparam logic [1:0] MODE_TYPE_A = 2'h1;
  localparam logic [1:0] MODE_TYPE_B = 2'h2;
  localparam logic [1:0] MODE_TYPE_F = 2'h3;
  localparam logic [1:0] MODE_RST = MODE_COMPAT;

  // ==========================================================
  // cycle lengths, in isa system clock periods
  localparam int CNT_W = 4;
  localparam logic [3:0] LEN_COMPAT_SINGLE = 4'h9;
  localparam logic [3:0] LEN_COMPAT_REP = 4'h8;
  localparam logic [3:0] LEN_TYPE_A = 4'h6;
  localparam logic [3:0] LEN_TYPE_B = 4'h5;
  localparam logic [3:0] LEN_TYPE_F = 4'h3;
  // periods before the io command asserts (write setup / read access lead)
  localparam logic [3:0] SETUP_STD = 4'h2;
  localparam logic [3:0] SETUP_FAST = 4'h1;
  // last period of every cycle is command recovery
  localparam logic [3:0] RECOVERY = 4'h1;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_RUN = 1'h1
  } dct_state_t;

endpackage : dct_pkg

/* File: dct_fifo.sv */
`timescale 1ns/100ps
module dct_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;

  // ==========================================================
  // handshake
  assign inReady = (count_r != (AW + 1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    ptrInc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'h1);
  endfunction : ptrInc

  // ==========================================================
  // storage and pointers
  always_comb begin
    mem_nxt = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt = ptrInc(wrPtr_r);
    end
    if (pop) begin
      rdPtr_nxt = ptrInc(rdPtr_r);
    end
    if (push && !pop) begin
      count_nxt = (AW + 1)'(count_r + 1'h1);
    end else if (pop && !push) begin
      count_nxt = (AW + 1)'(count_r - 1'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (en) begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      mem_r <= mem_nxt;
    end
  end

endmodule : dct_fifo

/* File: dct_isa_slave_model.sv */
`timescale 1ns/100ps
module dct_isa_slave_model #(
  parameter int HALF = 8
) (
  // clocks
  input wire logic sys_clk,
  output logic isaClk,
  // bus side
  input wire logic ioCmd,
  output int edgeCnt,
  output int cmdTaken
);
  // ==========
  // isa clock
  // made on sys_clk so the bench can count edges exactly; runs free
  int ph;
  initial begin
    isaClk = 1'h0;
    ph = 0;
    edgeCnt = 0;
    cmdTaken = 0;
  end
  always @(posedge sys_clk) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) begin
      isaClk <= ~isaClk;
      if (!isaClk) begin
        edgeCnt <= edgeCnt + 1;
      end
    end
  end
  // ==========
  // slave side
  // takes each io command at once, so one clock of setup is enough
  always @(posedge ioCmd) begin
    cmdTaken <= cmdTaken + 1;
  end
endmodule : dct_isa_slave_model

/* File: dct_cycle_timing_tb_top.sv */
`timescale 1ns/100ps
module dct_cycle_timing_tb_top;
  // ==========
  // signals
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic clkEn = 1'h1;
  logic isaClk;
  logic hostBusResetN = 1'h1;
  logic modeWrEn = 1'h0;
  logic [dct_pkg::WR_W-1:0] modeWrData = 8'h00;
  logic reqValid = 1'h0;
  logic reqReady;
  logic [1:0] reqChan = 2'h0;
  logic reqIsaMem = 1'h0;
  logic reqRepeat = 1'h0;
  logic cycBusy, ioCmd, cycDone;
  logic [1:0] doneChan, curMode;
  logic [7:0] chanModes;
  int edgeCnt;
  int cmdTaken;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2 sys_clk = ~sys_clk;

  dct_isa_slave_model isa_u (.sys_clk(sys_clk), .isaClk(isaClk), .ioCmd(ioCmd),
    .edgeCnt(edgeCnt), .cmdTaken(cmdTaken));

  dct_cycle_timing dut_u (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .isaSystemClock(isaClk), .hostBusResetN(hostBusResetN), .modeWrEn(modeWrEn),
    .modeWrData(modeWrData), .reqValid(reqValid), .reqReady(reqReady),
    .reqChan(reqChan), .reqIsaMem(reqIsaMem), .reqRepeat(reqRepeat),
    .cycBusy(cycBusy), .ioCmd(ioCmd), .cycDone(cycDone), .doneChan(doneChan),
    .curMode(curMode), .chanModes(chanModes));

  // ==========
  // helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [1:0] ch, input logic [1:0] code);
    @(posedge sys_clk);
    modeWrEn <= 1'h1;
    modeWrData <= {2'h2, code, 2'h3, ch};
    @(posedge sys_clk);
    modeWrEn <= 1'h0;
  endtask : wr

  // pushed just after an isa fall so no isa edge sits near the cycle start
  task automatic runCyc(input logic [1:0] ch, input logic mem, input logic rep,
      input logic [3:0] len, input logic [3:0] stp, input logic [1:0] md, input logic mid);
    int e0;
    int c0;
    int eIo;
    int k;
    @(negedge isaClk);
    @(posedge sys_clk);
    reqValid <= 1'h1;
    reqChan <= ch;
    reqIsaMem <= mem;
    reqRepeat <= rep;
    @(posedge sys_clk);
    reqValid <= 1'h0;
    k = 0;
    #1;
    while (cycBusy !== 1'h1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    e0 = edgeCnt;
    c0 = cmdTaken;
    eIo = -1;
    if (mid) begin
      wr(ch, 2'h0);
    end
    while (cycDone !== 1'h1 && k < 400) begin
      @(posedge sys_clk);
      #1;
      k++;
      if (ioCmd === 1'h1 && eIo < 0) begin
        eIo = edgeCnt - e0;
      end
    end
    chk("cycleEdges", 16'(len), 16'(edgeCnt - e0));
    chk("setupEdges", 16'(stp), 16'(eIo));
    chk("curMode", 16'(md), 16'(curMode));
    chk("doneChan", 16'(ch), 16'(doneChan));
    chk("ioCmds", 16'h0001, 16'(cmdTaken - c0));
    chk("ioCmdEnd", 16'h0000, 16'(ioCmd));
    chk("busyEnd", 16'h0000, 16'(cycBusy));
  endtask : runCyc

  // ==========
  // scenarios
  task automatic tModes();
    logic [7:0] exp;
    exp = 8'h00;
    for (int c = 0; c < 4; c++) begin
      wr(2'(c), 2'(3 - c));
      exp[2*c +: 2] = 2'(3 - c);
    end
    #1;
    chk("chanModes", 16'(exp), 16'(chanModes));
    @(posedge sys_clk);
    clkEn <= 1'h0;
    wr(2'h0, 2'h0);
    clkEn <= 1'h1;
    #1;
    chk("frozenModes", 16'(exp), 16'(chanModes));
    $display("modes done");
  endtask : tModes

  task automatic tTiming();
    logic [3:0] len[4] = '{4'h8, 4'h6, 4'h5, 4'h3};
    logic [3:0] stp[4] = '{4'h2, 4'h2, 4'h1, 4'h1};
    for (int m = 0; m < 4; m++) begin
      wr(2'h1, 2'(m));
      runCyc(2'h1, 1'h0, 1'h1, len[m], stp[m], 2'(m), 1'h0);
    end
    runCyc(2'h1, 1'h0, 1'h1, 4'h3, 4'h1, 2'h3, 1'h1);
    runCyc(2'h1, 1'h0, 1'h0, 4'h9, 4'h2, 2'h0, 1'h0);
    wr(2'h1, 2'h3);
    runCyc(2'h1, 1'h1, 1'h1, 4'h8, 4'h2, 2'h0, 1'h0);
    $display("timing done");
  endtask : tTiming

  task automatic tHostRst();
    wr(2'h2, 2'h3);
    @(posedge sys_clk);
    hostBusResetN <= 1'h0;
    repeat (4) @(posedge sys_clk);
    wr(2'h1, 2'h1);
    hostBusResetN <= 1'h1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("hostReset", 16'h0000, 16'(chanModes));
    $display("host reset done");
  endtask : tHostRst

  // all channels compatible here, so the queue stays full for a while
  task automatic tFifo();
    int n;
    int d;
    logic rdy;
    n = 0;
    d = 0;
    rdy = 1'h1;
    @(posedge sys_clk);
    reqIsaMem <= 1'h0;
    reqRepeat <= 1'h1;
    reqChan <= 2'h0;
    reqValid <= 1'h1;
    while (rdy === 1'h1 && n < 12) begin
      @(negedge sys_clk);
      rdy = reqReady;
      @(posedge sys_clk);
      if (rdy === 1'h1) begin
        n++;
        reqChan <= reqChan + 2'h1;
      end
    end
    reqValid <= 1'h0;
    chk("accepted", 16'h0009, 16'(n));
    for (int k = 0; k < 2500 && d < 9; k++) begin
      @(posedge sys_clk);
      #1;
      if (cycDone === 1'h1) begin
        chk("fifoOrder", 16'(d % 4), 16'(doneChan));
        d++;
      end
    end
    chk("drained", 16'h0009, 16'(d));
    chk("readyAgain", 16'h0001, 16'(reqReady));
    $display("fifo done");
  endtask : tFifo

  // ==========
  // main sequence and hang guard
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk("resetModes", 16'h0000, 16'(chanModes));
    chk("resetReady", 16'h0001, 16'(reqReady));
    tModes();
    tTiming();
    tHostRst();
    tFifo();
    conclude();
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      conclude();
    end
  end
endmodule : dct_cycle_timing_tb_top
